// *** dll_clk_ctrl.sv ***
// Purpose: digital control of the delay-locked loop plus the edge clock divider
// Assumes: all pins except the async divRst synchronous to mclk; wishbone classic slave on mclk
// Notes:   delay line modelled as a 64-tap shift of the sampled reference
module dll_clk_ctrl (
  // clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        ce,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // dll fabric side
  input  wire logic        refClkIn,
  input  wire logic        feedbackClkIn,
  input  wire logic        dllResetN,
  input  wire logic        adjustFreeze,
  input  wire logic        updateEnable,
  output logic             primaryClkOut,
  output logic             secondaryClkOut,
  output logic             lock,
  output logic             settingMismatch,
  // peer dll exchange
  input  wire logic        incrFromPeer,
  input  wire logic [5:0]  peerDelayCodeIn,
  output logic             incrToPeer,
  output logic [5:0]       delayCodeOut,
  // clock divider
  input  wire logic        divRst,
  input  wire logic        divRelease,
  output logic             divClkOut
);
  localparam int unsigned W = dll_clk_pkg::CODE_W;

  // control register fields
  logic [1:0]   divMode_reg;
  logic [1:0]   secMode_reg;
  logic         timeRef_reg;
  // bus
  logic         ack_reg;
  logic [31:0]  rdData_reg;
  logic [31:0]  rdWord;
  logic         reqCtrl;
  logic         reqStat;
  // dll state
  logic         ref_reg;
  logic         refPrev_reg;
  logic         refRise;
  logic [W-1:0] computed_reg;
  logic [W-1:0] computed_next;
  logic [W-1:0] applied_reg;
  logic [W-1:0] grayOut_reg;
  logic         incr_reg;
  logic         seenStep_reg;
  logic [3:0]   lockCnt_reg;
  logic         lock_reg;
  logic         mismatch_reg;
  logic         updPrev_reg;
  logic         updCmd;
  logic         dllClear;
  logic         stepDir;
  // delay line and secondary clock
  logic [dll_clk_pkg::DELAY_TAPS-1:0] delayLine_reg;
  logic         tap;
  logic         tapPrev_reg;
  logic [1:0]   secCnt_reg;
  logic         sec_reg;
  logic         primary_reg;
  logic         divRunning;

  // register bus
  always_comb begin
    reqCtrl = 1'b0;
    reqStat = 1'b0;
    if (adr_i == dll_clk_pkg::CTRL_OFS) begin
      reqCtrl = 1'b1;
    end else if (adr_i == dll_clk_pkg::STATUS_OFS) begin
      reqStat = 1'b1;
    end
  end

  always_comb begin
    rdWord = 32'h0000_0000;
    if (reqCtrl) begin
      rdWord[dll_clk_pkg::CTRL_DIV_LSB +: 2] = divMode_reg;
      rdWord[dll_clk_pkg::CTRL_SEC_LSB +: 2] = secMode_reg;
      rdWord[dll_clk_pkg::CTRL_TREF_BIT]     = timeRef_reg;
    end else if (reqStat) begin
      rdWord[dll_clk_pkg::STAT_CODE_LSB +: W] = computed_reg;
      rdWord[dll_clk_pkg::STAT_APPL_LSB +: W] = applied_reg;
      rdWord[dll_clk_pkg::STAT_LOCK_BIT]      = lock_reg;
      rdWord[dll_clk_pkg::STAT_MISM_BIT]      = mismatch_reg;
      rdWord[dll_clk_pkg::STAT_INCR_BIT]      = incr_reg;
      rdWord[dll_clk_pkg::STAT_RUN_BIT]       = divRunning;
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_reg    <= 1'b0;
      rdData_reg <= 32'h0000_0000;
    end else if (ce) begin
      ack_reg    <= cyc_i && stb_i && !ack_reg;
      rdData_reg <= rdWord;
    end
  end

  // write lands on the edge where ack is seen high
  always_ff @(posedge mclk) begin
    if (srst) begin
      divMode_reg <= dll_clk_pkg::CTRL_RESET[dll_clk_pkg::CTRL_DIV_LSB +: 2];
      secMode_reg <= dll_clk_pkg::CTRL_RESET[dll_clk_pkg::CTRL_SEC_LSB +: 2];
      timeRef_reg <= dll_clk_pkg::CTRL_RESET[dll_clk_pkg::CTRL_TREF_BIT];
    end else if (ce && ack_reg && cyc_i && stb_i && we_i && reqCtrl && sel_i[0]) begin
      divMode_reg <= dat_i[dll_clk_pkg::CTRL_DIV_LSB +: 2];
      secMode_reg <= dat_i[dll_clk_pkg::CTRL_SEC_LSB +: 2];
      timeRef_reg <= dat_i[dll_clk_pkg::CTRL_TREF_BIT];
    end
  end

  assign dat_o = rdData_reg;
  assign ack_o = ack_reg;

  // phase detector
  always_ff @(posedge mclk) begin
    if (srst) begin
      ref_reg     <= 1'b0;
      refPrev_reg <= 1'b0;
      primary_reg <= 1'b0;
    end else if (ce) begin
      ref_reg     <= refClkIn;
      refPrev_reg <= ref_reg;
      primary_reg <= ref_reg;
    end
  end

  assign refRise  = ref_reg && !refPrev_reg;
  // R6 synchronous dll reset
  assign dllClear = srst || !dllResetN;
  // feedback already high at reference edge means too much delay
  assign stepDir  = !feedbackClkIn;

  always_comb begin
    computed_next = computed_reg;
    if (timeRef_reg) begin
      // R10 follow peer code
      computed_next = dll_clk_pkg::gray2bin(peerDelayCodeIn);
    end else if (!adjustFreeze && refRise) begin
      // R7 freeze holds code
      if (stepDir && computed_reg != {W{1'b1}}) begin
        computed_next = computed_reg + {{(W-1){1'b0}}, 1'b1};
      end else if (!stepDir && computed_reg != {W{1'b0}}) begin
        computed_next = computed_reg - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (dllClear) begin
      computed_reg <= {W{1'b0}};
    end else if (ce) begin
      computed_reg <= computed_next;
    end
  end

  // R12 increment direction
  always_ff @(posedge mclk) begin
    if (dllClear) begin
      incr_reg     <= 1'b0;
      seenStep_reg <= 1'b0;
    end else if (ce) begin
      if (timeRef_reg) begin
        incr_reg <= incrFromPeer;
      end else if (!adjustFreeze && refRise) begin
        incr_reg     <= stepDir;
        seenStep_reg <= 1'b1;
      end
    end
  end

  // R9 lock after repeated direction reversals
  always_ff @(posedge mclk) begin
    if (dllClear) begin
      lockCnt_reg <= 4'h0;
      lock_reg    <= 1'b0;
    end else if (ce) begin
      if (timeRef_reg) begin
        lockCnt_reg <= dll_clk_pkg::LOCK_COUNT;
        lock_reg    <= 1'b1;
      end else if (!adjustFreeze && refRise && seenStep_reg) begin
        if (stepDir != incr_reg) begin
          if (lockCnt_reg != dll_clk_pkg::LOCK_COUNT) begin
            lockCnt_reg <= lockCnt_reg + 4'h1;
          end
          lock_reg <= (lockCnt_reg + 4'h1 >= dll_clk_pkg::LOCK_COUNT);
        end else begin
          lockCnt_reg <= 4'h0;
          lock_reg    <= 1'b0;
        end
      end
    end
  end

  // update of applied setting
  // R8 two-cycle update enable
  assign updCmd = updateEnable && updPrev_reg;

  always_ff @(posedge mclk) begin
    if (dllClear) begin
      updPrev_reg <= 1'b0;
      applied_reg <= {W{1'b0}};
      grayOut_reg <= {W{1'b0}};
    end else if (ce) begin
      updPrev_reg <= updateEnable && !updCmd;
      if (updCmd) begin
        applied_reg <= computed_reg;
        // R11 gray coded output
        grayOut_reg <= dll_clk_pkg::bin2gray(computed_reg);
      end
    end
  end

  // R13 mismatch flag
  always_ff @(posedge mclk) begin
    if (dllClear) begin
      mismatch_reg <= 1'b0;
    end else if (ce) begin
      mismatch_reg <= (computed_next != (updCmd ? computed_reg : applied_reg));
    end
  end

  // secondary clock
  always_ff @(posedge mclk) begin
    if (srst) begin
      delayLine_reg <= '0;
      tapPrev_reg   <= 1'b0;
    end else if (ce) begin
      delayLine_reg <= {delayLine_reg[dll_clk_pkg::DELAY_TAPS-2:0], ref_reg};
      tapPrev_reg   <= tap;
    end
  end

  assign tap = delayLine_reg[applied_reg];

  // R14 shifted, optionally divided
  always_ff @(posedge mclk) begin
    if (dllClear) begin
      secCnt_reg <= 2'h0;
      sec_reg    <= 1'b0;
    end else if (ce) begin
      case (secMode_reg)
        dll_clk_pkg::SEC_BY2: begin
          if (tap && !tapPrev_reg) begin
            sec_reg <= ~sec_reg;
          end
        end
        dll_clk_pkg::SEC_BY4: begin
          if (tap && !tapPrev_reg) begin
            secCnt_reg <= secCnt_reg + 2'h1;
            sec_reg    <= secCnt_reg[0] ? ~sec_reg : sec_reg;
          end
        end
        default: begin
          sec_reg <= tap;
        end
      endcase
    end
  end

  assign primaryClkOut   = primary_reg;
  assign secondaryClkOut = sec_reg;
  assign lock            = lock_reg;
  assign settingMismatch = mismatch_reg;
  assign incrToPeer      = incr_reg;
  assign delayCodeOut    = grayOut_reg;

  // clock divider
  clk_divider u_divider (
    .mclk       (mclk),
    .srst       (srst),
    .ce         (ce),
    .divRst     (divRst),
    .divRelease (divRelease),
    .divMode    (divMode_reg),
    .divClkOut  (divClkOut),
    .divRunning (divRunning)
  );

  // checks
  property p_dllReset;
    @(posedge mclk) disable iff (srst)
      !dllResetN |=> applied_reg == '0 && computed_reg == '0 && !lock && !settingMismatch;
  endproperty
  a_dllReset: assert property (p_dllReset) else $error("dll not cleared"); // R6

  property p_freeze;
    @(posedge mclk) disable iff (dllClear)
      (ce && adjustFreeze && !timeRef_reg) ##1 (dllResetN && !srst)
        |-> computed_reg == $past(computed_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("code moved while frozen"); // R7

  property p_update;
    @(posedge mclk) disable iff (dllClear)
      (ce && updateEnable && updPrev_reg) ##1 dllResetN
        |-> applied_reg == $past(computed_reg);
  endproperty
  a_update: assert property (p_update) else $error("update not applied"); // R8

  property p_noUpdate;
    @(posedge mclk) disable iff (dllClear)
      (!updateEnable || !updPrev_reg) ##1 dllResetN |-> $stable(applied_reg);
  endproperty
  a_noUpdate: assert property (p_noUpdate) else $error("applied moved without command"); // R8

  property p_lock;
    @(posedge mclk) disable iff (dllClear)
      lock |-> lockCnt_reg == dll_clk_pkg::LOCK_COUNT || timeRef_reg;
  endproperty
  a_lock: assert property (p_lock) else $error("lock without reversals"); // R9

  property p_peer;
    @(posedge mclk) disable iff (dllClear)
      (ce && timeRef_reg) ##1 dllResetN
        |-> computed_reg == dll_clk_pkg::gray2bin($past(peerDelayCodeIn));
  endproperty
  a_peer: assert property (p_peer) else $error("peer code not followed"); // R10

  property p_grayOut;
    @(posedge mclk) disable iff (srst)
      dll_clk_pkg::gray2bin(delayCodeOut) == applied_reg;
  endproperty
  a_grayOut: assert property (p_grayOut) else $error("gray output wrong"); // R11

  property p_mismatch;
    @(posedge mclk) disable iff (dllClear)
      settingMismatch == (computed_reg != applied_reg);
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch flag wrong"); // R13

  property p_incrPeer;
    @(posedge mclk) disable iff (dllClear)
      (ce && timeRef_reg) ##1 dllResetN |-> incrToPeer == $past(incrFromPeer);
  endproperty
  a_incrPeer: assert property (p_incrPeer) else $error("peer increment lost"); // R12

  property p_secPlain;
    @(posedge mclk) disable iff (dllClear)
      (ce && secMode_reg == dll_clk_pkg::SEC_NONE) ##1 dllResetN
        |-> secondaryClkOut == $past(tap);
  endproperty
  a_secPlain: assert property (p_secPlain) else $error("secondary not tap"); // R14

  property p_ack;
    @(posedge mclk) disable iff (srst)
      ack_o |=> !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held two cycles");

  c_lock:   cover property (@(posedge mclk) disable iff (dllClear) $rose(lock));
  c_update: cover property (@(posedge mclk) disable iff (dllClear) updCmd);
  c_tref:   cover property (@(posedge mclk) disable iff (srst) timeRef_reg && lock);
  c_sec4:   cover property (@(posedge mclk) disable iff (srst)
                            secMode_reg == dll_clk_pkg::SEC_BY4 && $rose(secondaryClkOut));
endmodule : dll_clk_ctrl

// *** dll_clk_pkg.sv ***
// Purpose: shared constants and helpers for the dll control and clock divider
// Assumes: one clock mclk at 40 MHz, synchronous active-high srst
// Notes:   register offsets are byte addresses on a 32-bit classic wishbone
//
// What this block does
// R1 - divider output is the edge clock divided by two, four or eight
// R2 - divided output phase is fixed by the moment of reset release
// R3 - divider reset forces all divider outputs low at once, no clock needed
// R4 - outputs start toggling only on release, synchronous to the input clock
// R5 - after release the count starts at zero, first rising edge aligned
// R6 - dll control state resets while dll reset input is low, sampled synchronously
// R7 - adjust freeze high holds the computed delay code unchanged; in time reference mode the code still follows the peer code
// R8 - update enable high two consecutive cycles applies the computed code
// R9 - lock output is high only while the loop is phase locked
// R10 - time reference mode takes the peer gray code as delay setting
// R11 - own applied delay code is driven out in gray code
// R12 - increment indicator goes out to peers and comes in from a peer
// R13 - mismatch output high whenever computed code differs from applied code
// R14 - secondary clock is a delay-shifted clock, optionally divided by two or four
package dll_clk_pkg;
  localparam int unsigned CODE_W     = 6;
  localparam int unsigned DELAY_TAPS = 64;
  localparam logic [3:0]  LOCK_COUNT = 4'h8;
  // register byte offsets
  localparam logic [3:0]  CTRL_OFS   = 4'h0;
  localparam logic [3:0]  STATUS_OFS = 4'h4;
  // control fields
  localparam int unsigned CTRL_DIV_LSB  = 0;
  localparam int unsigned CTRL_SEC_LSB  = 2;
  localparam int unsigned CTRL_TREF_BIT = 4;
  localparam logic [4:0]  CTRL_RESET    = 5'h00;
  // status fields
  localparam int unsigned STAT_CODE_LSB  = 0;
  localparam int unsigned STAT_APPL_LSB  = 8;
  localparam int unsigned STAT_LOCK_BIT  = 16;
  localparam int unsigned STAT_MISM_BIT  = 17;
  localparam int unsigned STAT_INCR_BIT  = 18;
  localparam int unsigned STAT_RUN_BIT   = 19;
  // divide selections
  localparam logic [1:0]  DIV_BY2  = 2'h0;
  localparam logic [1:0]  DIV_BY4  = 2'h1;
  localparam logic [1:0]  DIV_BY8  = 2'h2;
  localparam logic [1:0]  SEC_NONE = 2'h0;
  localparam logic [1:0]  SEC_BY2  = 2'h1;
  localparam logic [1:0]  SEC_BY4  = 2'h2;
  typedef enum logic {DIV_STOPPED, DIV_RUNNING} div_state_e;

  function automatic logic [CODE_W-1:0] bin2gray(input logic [CODE_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [CODE_W-1:0] gray2bin(input logic [CODE_W-1:0] g);
    logic [CODE_W-1:0] b;
    b[CODE_W-1] = g[CODE_W-1];
    for (int i = CODE_W-2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin
endpackage : dll_clk_pkg

// *** clk_divider.sv ***
// Purpose: edge clock divider, /2 /4 /8, with async reset and sync release
// Assumes: mclk is the edge clock; divRst may arrive at any time
// Notes:   output is a register cleared by the async reset
module clk_divider (
  // clock and control
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       ce,
  // divider control
  input  wire logic       divRst,
  input  wire logic       divRelease,
  input  wire logic [1:0] divMode,
  // divided clock
  output logic            divClkOut,
  output logic            divRunning
);
  dll_clk_pkg::div_state_e state_reg;
  logic [1:0]              cnt_reg;
  logic [1:0]              halfLast;

  always_comb begin
    case (divMode)
      dll_clk_pkg::DIV_BY4: halfLast = 2'h1;
      dll_clk_pkg::DIV_BY8: halfLast = 2'h3;
      default:              halfLast = 2'h0;
    endcase
  end

  // R3 async forced low
  always_ff @(posedge mclk or posedge divRst) begin
    if (divRst) begin
      state_reg <= dll_clk_pkg::DIV_STOPPED;
      cnt_reg   <= 2'h0;
      divClkOut <= 1'b0;
    end else if (srst) begin
      state_reg <= dll_clk_pkg::DIV_STOPPED;
      cnt_reg   <= 2'h0;
      divClkOut <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        dll_clk_pkg::DIV_STOPPED: begin
          // R4 synchronous release
          if (divRelease) begin
            state_reg <= dll_clk_pkg::DIV_RUNNING;
            // R5 R2 count from zero
            cnt_reg   <= 2'h0;
            divClkOut <= 1'b1;
          end
        end
        default: begin
          // R1 toggle every half period
          if (cnt_reg == halfLast) begin
            cnt_reg   <= 2'h0;
            divClkOut <= ~divClkOut;
          end else begin
            cnt_reg <= cnt_reg + 2'h1;
          end
        end
      endcase
    end
  end

  assign divRunning = (state_reg == dll_clk_pkg::DIV_RUNNING);

  property p_divHold;
    @(posedge mclk) disable iff (srst || divRst)
      (ce && divRunning && cnt_reg != halfLast) |=> $stable(divClkOut);
  endproperty
  a_divHold: assert property (p_divHold) else $error("divider toggled mid half"); // R1

  property p_divLow;
    @(posedge mclk) divRst |-> !divClkOut && !divRunning;
  endproperty
  a_divLow: assert property (p_divLow) else $error("divider output not low in reset"); // R3

  property p_divStart;
    @(posedge mclk) disable iff (srst || divRst)
      (ce && !divRunning && divRelease) |=> divClkOut && cnt_reg == 2'h0;
  endproperty
  a_divStart: assert property (p_divStart) else $error("divider start misaligned"); // R5

  property p_divWait;
    @(posedge mclk) disable iff (srst || divRst)
      (!divRunning && !divRelease) |=> !divClkOut;
  endproperty
  a_divWait: assert property (p_divWait) else $error("divider ran without release"); // R4

  c_divRun: cover property (@(posedge mclk) disable iff (srst) $fell(divClkOut));
endmodule : clk_divider

// *** dll_peer_model.sv ***
// Purpose: far-side model, fabric reference clocks and a neighbouring dll
// Assumes: mclk is the sampling clock of the device under test
// Notes:   feedback lags the reference by half a period, code is loaded by the bench from loadBin
module dll_peer_model #(
  parameter int unsigned REF_HALF = 4
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // bench control of the peer code
  input  wire logic       load,
  input  wire logic [5:0] loadBin,
  // toward the dll
  output logic            refClkIn,
  output logic            feedbackClkIn,
  output logic [5:0]      peerCode,
  output logic            peerIncr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] phaseReg;
  logic [5:0] binReg;

  // reference square wave, feedback is its half-period shifted copy
  always_ff @(posedge mclk) begin
    if (srst || phaseReg == 8'(2 * REF_HALF - 1)) begin
      phaseReg <= 8'h00;
    end else begin
      phaseReg <= phaseReg + 8'h01;
    end
    refClkIn      <= !srst && (phaseReg < 8'(REF_HALF));
    feedbackClkIn <= !srst && !(phaseReg < 8'(REF_HALF));
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      binReg   <= 6'h00;
      peerCode <= 6'h00;
      peerIncr <= 1'b0;
    end else if (load) begin
      binReg   <= loadBin;
      peerCode <= loadBin ^ (loadBin >> 1);
      peerIncr <= loadBin > binReg;
    end
  end
endmodule : dll_peer_model

// *** test_dll_clk_ctrl.sv ***
// Purpose: self-checking bench of dll control and clock divider
// Assumes: wishbone classic master, ack awaited until it comes or the watchdog ends the run
// Notes:   random peer codes from a fixed seed
module test_dll_clk_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, srst, cyc, stb, we, ack, refClk, fbClk, dllResetN;
  logic        adjustFreeze, updateEnable, primClk, secClk, lock, mism;
  logic        incrPeer, incrOut, divRst, divRelease, divClk, load, ce, prevSec;
  logic [1:0]  refHist;
  logic [3:0]  adr;
  logic [31:0] datW, datR, rd;
  logic [5:0]  peerCode, codeOut, loadBin, nb, applied;
  int          n_errors, checks, seed, tog;
  int          halves [4] = '{1, 2, 4, 1};

  dll_clk_ctrl i_dut (.mclk(mclk), .srst(srst), .ce(ce), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(datW), .dat_o(datR), .ack_o(ack),
    .refClkIn(refClk), .feedbackClkIn(fbClk), .dllResetN(dllResetN),
    .adjustFreeze(adjustFreeze), .updateEnable(updateEnable), .primaryClkOut(primClk),
    .secondaryClkOut(secClk), .lock(lock), .settingMismatch(mism),
    .incrFromPeer(incrPeer), .peerDelayCodeIn(peerCode), .incrToPeer(incrOut),
    .delayCodeOut(codeOut), .divRst(divRst), .divRelease(divRelease), .divClkOut(divClk));
  dll_peer_model i_peer (.mclk(mclk), .srst(srst), .load(load), .loadBin(loadBin),
    .refClkIn(refClk), .feedbackClkIn(fbClk), .peerCode(peerCode), .peerIncr(incrPeer));

  function automatic logic [5:0] to_gray(input logic [5:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray
  function automatic logic exp_div(input int k, input int h);
    return ((k / h) % 2) == 0;
  endfunction : exp_div

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    datW <= d;
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    rd  = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic upd(input int n);
    @(posedge mclk);
    updateEnable <= 1'b1;
    tick(n);
    updateEnable <= 1'b0;
  endtask : upd

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    {cyc, stb, we, updateEnable, divRst, divRelease, load} = '0;
    ce = 1'b1;
    {adr, datW, loadBin, applied} = '0;
    srst = 1'b1;
    dllResetN = 1'b1;
    adjustFreeze = 1'b1;
    seed = 27;
    tick(8);
    srst <= 1'b0;
    wb(1'b0, 4'h8, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, rd);
    tick(40);
    wb(1'b0, 4'h4, 32'h0000_0000);
    chk("frozen code", 32'h0000_0000, {26'h0, rd[5:0]});
    adjustFreeze <= 1'b0;
    for (int j = 0; j < 60; j++) begin
      @(posedge mclk);
      #1;
      if (j >= 2) chk("primary", refHist[1], primClk);
      refHist = {refHist[0], refClk};
    end
    wb(1'b0, 4'h4, 32'h0000_0000);
    chk("code moves", 32'h0000_0001, {31'h0, rd[5:0] != 6'h00});
    chk("no lock", 1'b0, lock);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, 4'h0, 32'(m));
      @(posedge mclk);
      divRst <= 1'b1;
      #1;
      chk("div async low", 1'b0, divClk);
      @(posedge mclk);
      divRst <= 1'b0;
      tick(4);
      #1;
      chk("div stopped", 1'b0, divClk);
      @(posedge mclk);
      divRelease <= 1'b1;
      @(posedge mclk);
      divRelease <= 1'b0;
      for (int k = 0; k < 16; k++) begin
        #1;
        chk("div phase", exp_div(k, halves[m]), divClk);
        @(posedge mclk);
      end
    end
    ce <= 1'b0;
    tick(3);
    #1;
    chk("ce freeze", exp_div(16, halves[3]), divClk);
    @(posedge mclk);
    ce <= 1'b1;
    @(posedge mclk);
    #1;
    chk("ce resume", exp_div(17, halves[3]), divClk);
    wb(1'b1, 4'h0, 32'h0000_0010);
    wb(1'b0, 4'h0, 32'h0000_0000);
    chk("ctrl readback", 32'h0000_0010, rd);
    tick(3);
    #1;
    chk("tref lock", 1'b1, lock);
    for (int i = 0; i < 5; i++) begin
      nb = 6'($random(seed));
      if (nb == applied) nb = nb ^ 6'h01;
      @(posedge mclk);
      load    <= 1'b1;
      loadBin <= nb;
      @(posedge mclk);
      load <= 1'b0;
      tick(3);
      #1;
      chk("mismatch raised", 1'b1, mism);
      chk("incr follows", 32'(nb > applied), incrOut);
      wb(1'b0, 4'h4, 32'h0000_0000);
      chk("computed code", nb, rd[5:0]);
      upd(1);
      tick(2);
      #1;
      chk("single pulse", to_gray(applied), codeOut);
      upd(2);
      tick(1);
      #1;
      chk("gray out", to_gray(nb), codeOut);
      chk("mismatch clear", 1'b0, mism);
      applied = nb;
    end
    // ref period is eight cycles, so 64 cycles hold 8 or 4 toggles
    for (int s = 1; s < 3; s++) begin
      wb(1'b1, 4'h0, 32'h0000_0010 | 32'(s << 2));
      tick(2);
      #1;
      prevSec = secClk;
      tog = 0;
      for (int j = 0; j < 64; j++) begin
        @(posedge mclk);
        #1;
        if (secClk !== prevSec) tog++;
        prevSec = secClk;
      end
      chk("secondary toggles", 32'(8 / s), 32'(tog));
    end
    @(posedge mclk);
    dllResetN <= 1'b0;
    tick(2);
    #1;
    chk("reset code", 6'h00, codeOut);
    chk("reset lock", 1'b0, lock);
    chk("reset sec", 1'b0, secClk);
    dllResetN <= 1'b1;
    tally_and_finish();
  end
endmodule : test_dll_clk_ctrl
